// ===== hdl/pwb_top.sv
// Dual-output 12-bit PWM unit: prescaler, counters, compare, pin styles, APB registers
`timescale 1ns/1ps
// What this block does
// - extra compare keeps bits 7..4, low reads zero
// - high width equals width compare times prescaler period
// - zero extra field gives plain 8-bit PWM
// - prescaler period is divider plus one counts
// - select bit zero system clock, one oscillator
// - upper select register bits do nothing here
// - twelve-bit compare, eight width, four extra
// - overall period is sixteen fundamental periods
// - fundamental period is (field+1) times sixteen
// - pin six style from select, latch, direction
// - pin seven uses the same four styles
// - match buffer drops output, reloads at zero
// - control bits 3 and 2 run B, A
// - wrap flag each overall period, interrupt when enabled
// - stopped channel waveform held low
module pwb_top
(
	input  wire logic                        REF_CLK_I,     // System clock, 25 MHz
	input  wire logic                        RST_I,         // Synchronous reset, active high
	input  wire logic                        OSC_CLK_I,     // Secondary oscillator clock
	input  wire logic                        PSEL_I,        // APB select
	input  wire logic                        PENABLE_I,     // APB access phase
	input  wire logic                        PWRITE_I,      // APB direction
	input  wire logic [pwb_pkg::ADDR_W-1:0]  PADDR_I,       // APB byte address
	input  wire logic [31:0]                 PWDATA_I,      // APB write data
	input  wire logic [3:0]                  PSTRB_I,       // APB byte strobes
	output logic      [31:0]                 PRDATA_O,      // APB read data
	output logic                             PREADY_O,      // APB ready
	output logic                             PSLVERR_O,     // APB error
	output logic                             IRQ_O,         // Level interrupt
	output logic                             PIN_SIX_OUT_O, // Pin six driven level
	output logic                             PIN_SIX_OE_O,  // Pin six driver on
	output logic                             PIN_SIX_SLOW_O,// Pin six slow-edge mode
	output logic                             PIN_SEVEN_OUT_O,  // Pin seven driven level
	output logic                             PIN_SEVEN_OE_O,   // Pin seven driver on
	output logic                             PIN_SEVEN_SLOW_O  // Pin seven slow-edge mode
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [7:0]  extra_cmp_r [pwb_pkg::NUM_CH];   // Extra-pulse compare, per channel
	logic [7:0]  width_cmp_r [pwb_pkg::NUM_CH];   // Width compare, per channel
	logic [7:0]  width_buf_r [pwb_pkg::NUM_CH];   // Width match buffer
	logic [3:0]  extra_buf_r [pwb_pkg::NUM_CH];   // Extra field buffer
	logic [1:0]  pwm_r;                           // Raw waveform per channel
	logic [1:0]  run;                             // Channel running
	logic [3:0]  period_field_r;                  // Fundamental length field
	logic [1:0]  run_r;                           // run_b, run_a
	logic        wrap_flag_r;                     // Sticky overall-period event
	logic        irq_enable_r;                    // Interrupt mask
	logic [7:0]  prescale_divider_r;              // Prescaler divider
	logic [7:0]  count_clock_select_r;            // Clock select register
	logic [7:0]  port_cfg_r;                      // Pin style bits, pin six low
	logic        osc_s1_r;                        // Oscillator sync stage one
	logic        osc_s2_r;                        // Oscillator sync stage two
	logic        osc_s3_r;                        // Oscillator edge history
	logic        count_tick;                      // Prescaler count enable
	logic [7:0]  pre_cnt_r;                       // Prescaler counter
	logic        pre_match;                       // Prescaler period end
	logic [7:0]  fund_cnt_r;                      // Fundamental wave counter
	logic [7:0]  fund_end;                        // Last count of a fundamental
	logic        fund_match;                      // Fundamental period end
	logic [3:0]  add_cnt_r;                       // Additional pulse counter
	logic        unit_run;                        // Either channel running
	logic        wrap_set;                        // Overall period end
	logic        acc;                             // APB access cycle
	logic        wr_en;                           // Write takes effect now
	logic        wr_clear_wrap;                   // Write one to wrap flag
	logic [15:0] idx;                             // Register index of address
	logic        idx_hit;                         // Address maps to a register
	logic [7:0]  rd_byte;                         // Selected read value
	logic [7:0]  wbyte;                           // Write data low byte

	// ----------------------------------------
	// Run state and ticks
	// ----------------------------------------
	assign run      = run_r;
	assign unit_run = |run_r;

	// Oscillator synchroniser, edge taken after stage two
	always_ff @(posedge REF_CLK_I)
	begin
		if (RST_I)
		begin
			osc_s1_r <= 1'b0;
			osc_s2_r <= 1'b0;
			osc_s3_r <= 1'b0;
		end
		else
		begin
			osc_s1_r <= OSC_CLK_I;
			osc_s2_r <= osc_s1_r;
			osc_s3_r <= osc_s2_r;
		end
	end

	// Count clock source: every cycle or oscillator rising edge
	// Only bit 0 is looked at; the rest of the register is inert here
	assign count_tick = count_clock_select_r[pwb_pkg::CLK_SRC_BIT]
		? (osc_s2_r & ~osc_s3_r) : 1'b1;

	// Prescaler ends a period after divider+1 counts
	assign pre_match = count_tick && (pre_cnt_r == prescale_divider_r);

	// Prescaler counter, cleared while stopped or on match
	always_ff @(posedge REF_CLK_I)
	begin
		if (RST_I || !unit_run || pre_match)
			pre_cnt_r <= pwb_pkg::CNT_ZERO;
		else if (count_tick)
			pre_cnt_r <= 8'(pre_cnt_r + 8'h01);
	end

	// ----------------------------------------
	// Fundamental and additional pulse counters
	// ----------------------------------------
	// Last count is (field+1)*16-1, i.e. field in top nibble, low nibble all ones
	assign fund_end   = {period_field_r, pwb_pkg::FUND_LOW_END};
	assign fund_match = pre_match && (fund_cnt_r == fund_end);

	// Fundamental counter, cleared while stopped or at its end
	always_ff @(posedge REF_CLK_I)
	begin
		if (RST_I || !unit_run || fund_match)
			fund_cnt_r <= pwb_pkg::CNT_ZERO;
		else if (pre_match)
			fund_cnt_r <= 8'(fund_cnt_r + 8'h01);
	end

	// Additional pulse counter, cleared only by reset
	always_ff @(posedge REF_CLK_I)
	begin
		if (RST_I)
			add_cnt_r <= pwb_pkg::RST_NIBBLE;
		else if (fund_match)
			add_cnt_r <= 4'(add_cnt_r + 4'h1);
	end

	// Sixteenth fundamental closes an overall period
	assign wrap_set = fund_match && (add_cnt_r == pwb_pkg::LAST_FUND);

	// ----------------------------------------
	// Per-channel compare and waveform
	// ----------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < pwb_pkg::NUM_CH; ch++)
		begin : g_ch
			logic [3:0] slot_rev;  // Bit-reversed period number
			logic       extra_hit; // This period takes an extra pulse
			logic [8:0] high_len;  // High time in prescaler periods

			// Bit reversal spreads the chosen periods evenly over sixteen
			assign slot_rev  = {add_cnt_r[0], add_cnt_r[1], add_cnt_r[2], add_cnt_r[3]};
			assign extra_hit = (slot_rev < extra_buf_r[ch]);
			// Zero extra field never hits, leaving plain 8-bit PWM
			assign high_len  = {1'b0, width_buf_r[ch]} + {8'h00, extra_hit};

			// Match buffers track when stopped, reload at counter zero
			always_ff @(posedge REF_CLK_I)
			begin
				if (RST_I)
				begin
					width_buf_r[ch] <= pwb_pkg::RST_BYTE;
					extra_buf_r[ch] <= pwb_pkg::RST_NIBBLE;
				end
				else if (!run[ch] || fund_match)
				begin
					width_buf_r[ch] <= width_cmp_r[ch];
					extra_buf_r[ch] <= extra_cmp_r[ch][7:pwb_pkg::EXTRA_LSB];
				end
			end

			// High from counter zero until the buffer is matched
			always_ff @(posedge REF_CLK_I)
			begin
				if (RST_I || !run[ch])
					pwm_r[ch] <= 1'b0;
				else
					pwm_r[ch] <= ({1'b0, fund_cnt_r} < high_len);
			end
		end
	endgenerate

	// ----------------------------------------
	// Pin output styles
	// ----------------------------------------
	// Style decode: FSA must be one; FSB, latch, direction pick the driver
	function automatic logic [2:0] pin_style(input logic [3:0] cfg, input logic wave);
		logic [2:0] res; // {out, oe, slow}
		res = 3'h0;
		if (cfg[pwb_pkg::PORT_FSA])
		begin
			unique case ({cfg[pwb_pkg::PORT_FSB], cfg[pwb_pkg::PORT_LAT], cfg[pwb_pkg::PORT_DIR]})
				3'h2:    res = {~wave, 1'b1, 1'b0}; // Inverted push-pull
				3'h1:    res = {wave, 1'b1, 1'b0};  // Push-pull
				3'h6:    res = {wave, 1'b1, 1'b1};  // Slow-edge push-pull
				3'h5:    res = {1'b0, ~wave, 1'b0}; // Open drain, pulls low only
				default: res = 3'h0;                // Not a PWM setting, released
			endcase
		end
		return res;
	endfunction

	// Registered pin drivers
	always_ff @(posedge REF_CLK_I)
	begin
		if (RST_I)
		begin
			{PIN_SIX_OUT_O, PIN_SIX_OE_O, PIN_SIX_SLOW_O}       <= 3'h0;
			{PIN_SEVEN_OUT_O, PIN_SEVEN_OE_O, PIN_SEVEN_SLOW_O} <= 3'h0;
		end
		else
		begin
			{PIN_SIX_OUT_O, PIN_SIX_OE_O, PIN_SIX_SLOW_O}       <= pin_style(port_cfg_r[3:0], pwm_r[0]);
			{PIN_SEVEN_OUT_O, PIN_SEVEN_OE_O, PIN_SEVEN_SLOW_O} <= pin_style(port_cfg_r[7:4], pwm_r[1]);
		end
	end

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	assign acc     = PSEL_I && PENABLE_I && PREADY_O;
	assign idx     = 16'(PADDR_I[pwb_pkg::ADDR_W-1:2]);
	assign wbyte   = PWDATA_I[7:0];
	assign wr_en   = acc && PWRITE_I && idx_hit && PSTRB_I[0];
	assign wr_clear_wrap = wr_en && (((idx == pwb_pkg::IDX_CONTROL) && wbyte[pwb_pkg::CTL_WRAP_FLAG])
		|| ((idx == pwb_pkg::IDX_IRQ_STATUS) && wbyte[pwb_pkg::IRQ_WRAP]));

	// Read mux and map check
	always_comb
	begin
		idx_hit = (PADDR_I[1:0] == pwb_pkg::WORD_ALIGN);
		rd_byte = 8'h00;
		unique case (idx)
			pwb_pkg::IDX_CHAN_A_EXTRA: rd_byte = {extra_cmp_r[0][7:4], 4'h0}; // Low nibble reads zero
			pwb_pkg::IDX_CHAN_A_WIDTH: rd_byte = width_cmp_r[0];
			pwb_pkg::IDX_CHAN_B_EXTRA: rd_byte = {extra_cmp_r[1][7:4], 4'h0};
			pwb_pkg::IDX_CHAN_B_WIDTH: rd_byte = width_cmp_r[1];
			pwb_pkg::IDX_CONTROL:      rd_byte = {period_field_r, run_r, wrap_flag_r, irq_enable_r};
			pwb_pkg::IDX_PRESCALE:     rd_byte = prescale_divider_r;
			pwb_pkg::IDX_CLOCK_SELECT: rd_byte = count_clock_select_r;
			pwb_pkg::IDX_PORT_CONFIG:  rd_byte = port_cfg_r;
			pwb_pkg::IDX_IRQ_STATUS:   rd_byte = {7'h00, wrap_flag_r};
			pwb_pkg::IDX_IRQ_MASK:     rd_byte = {7'h00, irq_enable_r};
			default:                   idx_hit = 1'b0;   // Unmapped word
		endcase
	end

	// Ready after one wait state; data and error registered with it
	always_ff @(posedge REF_CLK_I)
	begin
		if (RST_I)
		begin
			PREADY_O  <= 1'b0;
			PRDATA_O  <= 32'h0000_0000;
			PSLVERR_O <= 1'b0;
		end
		else
		begin
			PREADY_O  <= PSEL_I && PENABLE_I && !PREADY_O;
			PSLVERR_O <= PSEL_I && PENABLE_I && !PREADY_O && !idx_hit;
			if (PSEL_I && PENABLE_I && !PREADY_O && !PWRITE_I && idx_hit)
				PRDATA_O <= {24'h00_0000, rd_byte};
			else
				PRDATA_O <= 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	// Compare registers; extra registers store only the top nibble
	always_ff @(posedge REF_CLK_I)
	begin
		if (RST_I)
		begin
			extra_cmp_r[0] <= pwb_pkg::RST_BYTE;
			extra_cmp_r[1] <= pwb_pkg::RST_BYTE;
			width_cmp_r[0] <= pwb_pkg::RST_BYTE;
			width_cmp_r[1] <= pwb_pkg::RST_BYTE;
		end
		else if (wr_en)
		begin
			if (idx == pwb_pkg::IDX_CHAN_A_EXTRA)
				extra_cmp_r[0] <= {wbyte[7:4], 4'h0};
			if (idx == pwb_pkg::IDX_CHAN_B_EXTRA)
				extra_cmp_r[1] <= {wbyte[7:4], 4'h0};
			if (idx == pwb_pkg::IDX_CHAN_A_WIDTH)
				width_cmp_r[0] <= wbyte;
			if (idx == pwb_pkg::IDX_CHAN_B_WIDTH)
				width_cmp_r[1] <= wbyte;
		end
	end

	// Control fields other than the flag
	always_ff @(posedge REF_CLK_I)
	begin
		if (RST_I)
		begin
			period_field_r <= pwb_pkg::RST_NIBBLE;
			run_r          <= 2'h0;
			irq_enable_r   <= 1'b0;
		end
		else if (wr_en && (idx == pwb_pkg::IDX_CONTROL))
		begin
			period_field_r <= wbyte[7:pwb_pkg::CTL_PERIOD_LSB];
			run_r          <= {wbyte[pwb_pkg::CTL_RUN_B], wbyte[pwb_pkg::CTL_RUN_A]};
			irq_enable_r   <= wbyte[pwb_pkg::CTL_IRQ_ENABLE];
		end
		else if (wr_en && (idx == pwb_pkg::IDX_IRQ_MASK))
			irq_enable_r   <= wbyte[pwb_pkg::IRQ_WRAP];
	end

	// Wrap flag: set wins over a write-one clear
	always_ff @(posedge REF_CLK_I)
	begin
		if (RST_I)
			wrap_flag_r <= 1'b0;
		else if (wrap_set)
			wrap_flag_r <= 1'b1;
		else if (wr_clear_wrap)
			wrap_flag_r <= 1'b0;
	end

	// Prescaler, clock select and port configuration
	// A select change while running is not guarded; software stops first
	always_ff @(posedge REF_CLK_I)
	begin
		if (RST_I)
		begin
			prescale_divider_r   <= pwb_pkg::RST_BYTE;
			count_clock_select_r <= pwb_pkg::RST_BYTE;
			port_cfg_r           <= pwb_pkg::RST_BYTE;
		end
		else if (wr_en)
		begin
			if (idx == pwb_pkg::IDX_PRESCALE)
				prescale_divider_r <= wbyte;
			if (idx == pwb_pkg::IDX_CLOCK_SELECT)
				count_clock_select_r <= wbyte;
			if (idx == pwb_pkg::IDX_PORT_CONFIG)
				port_cfg_r <= wbyte;
		end
	end

	// ----------------------------------------
	// Interrupt
	// ----------------------------------------
	// Level request while flag and enable are both set
	always_ff @(posedge REF_CLK_I)
	begin
		if (RST_I)
			IRQ_O <= 1'b0;
		else
			IRQ_O <= wrap_flag_r && irq_enable_r;
	end

endmodule

// ===== hdl/pwb_pkg.sv
// Shared constants for the dual-output 12-bit PWM unit with prescaler
package pwb_pkg;

	// ----------------------------------------
	// Register indices (byte address = 4 x index)
	// ----------------------------------------
	localparam logic [15:0] IDX_CHAN_A_EXTRA   = 16'h7FAA; // A extra-pulse compare
	localparam logic [15:0] IDX_CHAN_A_WIDTH   = 16'h7FAB; // A width compare
	localparam logic [15:0] IDX_CHAN_B_EXTRA   = 16'h7FAC; // B extra-pulse compare
	localparam logic [15:0] IDX_CHAN_B_WIDTH   = 16'h7FAD; // B width compare
	localparam logic [15:0] IDX_CONTROL        = 16'h7FAE; // Period, runs, flag, enable
	localparam logic [15:0] IDX_PRESCALE       = 16'h7FAF; // Prescale divider
	localparam logic [15:0] IDX_CLOCK_SELECT   = 16'h7FB6; // Count clock select
	localparam logic [15:0] IDX_PORT_CONFIG    = 16'h7FC0; // Pin style bits, both pins
	localparam logic [15:0] IDX_IRQ_STATUS     = 16'h7FC1; // Sticky events, write one to clear
	localparam logic [15:0] IDX_IRQ_MASK       = 16'h7FC2; // Event mask

	// ----------------------------------------
	// Bus geometry
	// ----------------------------------------
	localparam int          ADDR_W             = 18;       // Byte address width
	localparam logic [1:0]  WORD_ALIGN         = 2'h0;     // Low address bits of a word

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0]  RST_BYTE           = 8'h00;    // All registers clear
	localparam logic [3:0]  RST_NIBBLE         = 4'h0;     // Nibble-wide state
	localparam logic [7:0]  CNT_ZERO           = 8'h00;    // Counter restart value

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int          CTL_PERIOD_LSB     = 4;        // period_field bits 7..4
	localparam int          CTL_RUN_B          = 3;        // run_b
	localparam int          CTL_RUN_A          = 2;        // run_a
	localparam int          CTL_WRAP_FLAG      = 1;        // wrap_flag
	localparam int          CTL_IRQ_ENABLE     = 0;        // irq_enable
	localparam int          EXTRA_LSB          = 4;        // Extra-pulse field bits 7..4
	localparam int          CLK_SRC_BIT        = 0;        // clock_source_bit
	localparam int          PORT_FSA           = 0;        // Function select A in a nibble
	localparam int          PORT_FSB           = 1;        // Function select B in a nibble
	localparam int          PORT_LAT           = 2;        // Latch bit in a nibble
	localparam int          PORT_DIR           = 3;        // Direction bit in a nibble
	localparam int          IRQ_WRAP           = 0;        // Overall-period event bit

	// ----------------------------------------
	// Waveform geometry
	// ----------------------------------------
	localparam logic [3:0]  FUND_LOW_END       = 4'hF;     // 16 prescaler periods per step
	localparam logic [3:0]  LAST_FUND          = 4'hF;     // 16 fundamentals per overall
	localparam int          NUM_CH             = 2;        // Channel A and B

endpackage

// ===== verif/pwb_assertions.sv
// Concurrent checks on the bus and pin ports of the PWM unit
`timescale 1ns/1ps
module pwb_assertions
(
	input wire logic                       REF_CLK_I,
	input wire logic                       RST_I,
	input wire logic                       OSC_CLK_I,
	input wire logic                       PSEL_I,
	input wire logic                       PENABLE_I,
	input wire logic                       PWRITE_I,
	input wire logic [pwb_pkg::ADDR_W-1:0] PADDR_I,
	input wire logic [31:0]                PWDATA_I,
	input wire logic [3:0]                 PSTRB_I,
	input wire logic [31:0]                PRDATA_O,
	input wire logic                       PREADY_O,
	input wire logic                       PSLVERR_O,
	input wire logic                       IRQ_O,
	input wire logic                       PIN_SIX_OUT_O,
	input wire logic                       PIN_SIX_OE_O,
	input wire logic                       PIN_SIX_SLOW_O,
	input wire logic                       PIN_SEVEN_OUT_O,
	input wire logic                       PIN_SEVEN_OE_O,
	input wire logic                       PIN_SEVEN_SLOW_O
);
	// ----------------------------------------
	// Clock, reset and bus phases
	// ----------------------------------------
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);
	sequence s_setup;
		PSEL_I && !PENABLE_I;
	endsequence
	sequence s_access;
		PSEL_I && PENABLE_I;
	endsequence
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	a_ready_wait: assert property (s_setup ##1 s_access |=> PREADY_O)
		else $error("ready missing in second access cycle");
	a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
		else $error("ready longer than one cycle");
	a_ready_access: assert property (PREADY_O |-> s_access)
		else $error("ready outside an access phase");
	a_err_ready: assert property (PSLVERR_O |-> PREADY_O)
		else $error("error without ready");
	a_rdata_quiet: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
		else $error("read data outside ready cycle");
	a_rdata_byte: assert property (PREADY_O |-> PRDATA_O[31:8] == 24'h0)
		else $error("upper read data not zero");
	a_extra_nibble: assert property (PREADY_O && !PWRITE_I && PADDR_I == {pwb_pkg::IDX_CHAN_B_EXTRA, 2'h0}
		|-> PRDATA_O[3:0] == 4'h0) else $error("extra compare low bits not zero");
	a_unaligned_err: assert property (PREADY_O && PADDR_I[1:0] != pwb_pkg::WORD_ALIGN |-> PSLVERR_O)
		else $error("unaligned access not refused");
	a_six_drive: assert property (PIN_SIX_OUT_O || PIN_SIX_SLOW_O |-> PIN_SIX_OE_O)
		else $error("pin six level without driver");
	a_seven_drive: assert property (PIN_SEVEN_OUT_O || PIN_SEVEN_SLOW_O |-> PIN_SEVEN_OE_O)
		else $error("pin seven level without driver");
endmodule
bind pwb_top pwb_assertions u_chk (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .OSC_CLK_I(OSC_CLK_I), .PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I),
	.PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .IRQ_O(IRQ_O), .PIN_SIX_OUT_O(PIN_SIX_OUT_O),
	.PIN_SIX_OE_O(PIN_SIX_OE_O), .PIN_SIX_SLOW_O(PIN_SIX_SLOW_O), .PIN_SEVEN_OUT_O(PIN_SEVEN_OUT_O),
	.PIN_SEVEN_OE_O(PIN_SEVEN_OE_O), .PIN_SEVEN_SLOW_O(PIN_SEVEN_SLOW_O));

// ===== verif/pwb_top_tb_top.sv
// Self-checking bench for the PWM unit: registers, waveforms, pin styles, interrupt
`timescale 1ns/1ps
module pwb_top_tb_top;
	// ----------------------------------------
	// Stimulus and observation signals
	// ----------------------------------------
	logic        clk = 1'b0;       // System clock
	logic        rst = 1'b1;       // Reset
	logic        osc = 1'b0;       // Oscillator clock, four system cycles
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic [17:0] paddr = 18'h0;
	logic [1:0]  addr_lsb = 2'h0;  // Low byte-address bits of the next transfer
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, irq;
	logic [5:0]  pin;              // Seven out/oe/slow, six out/oe/slow
	logic [7:0]  rd;               // Last read byte
	logic        er;               // Last error response
	int          fails = 0;
	int          n_checks = 0;
	int          cyc = 0;
	int          cnt [6];

	initial forever #20 clk = ~clk;
	initial forever #80 osc = ~osc;
	always @(posedge clk) cyc <= cyc + 1;

	pwb_top DUT (.REF_CLK_I(clk), .RST_I(rst), .OSC_CLK_I(osc), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hF), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .IRQ_O(irq), .PIN_SIX_OUT_O(pin[3]), .PIN_SIX_OE_O(pin[4]), .PIN_SIX_SLOW_O(pin[5]),
		.PIN_SEVEN_OUT_O(pin[0]), .PIN_SEVEN_OE_O(pin[1]), .PIN_SEVEN_SLOW_O(pin[2]));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// One APB transfer; held until ready is seen at a rising edge
	task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] wd);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= {idx, addr_lsb};
		pwdata <= {24'h0, wd};
		@(posedge clk);
		pen <= 1'b1;
		for (n = 0; n < 16 && pready !== 1'b1; n++)
			@(posedge clk);
		if (pready !== 1'b1)
		begin
			fails++;
			conclude();
		end
		rd = prdata[7:0];
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic wr(input logic [15:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask
	task automatic rdchk(input string name, input logic [15:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		check(name, rd, exp);
	endtask
	// Stop, program both channels with width two, then start
	task automatic cfg(input logic [7:0] dv, input logic [7:0] ex, input logic [7:0] cs, input logic [7:0] pc,
		input logic [7:0] ctl);
		wr(pwb_pkg::IDX_CONTROL, 8'h00);
		wr(pwb_pkg::IDX_PRESCALE, dv);
		wr(pwb_pkg::IDX_CHAN_B_EXTRA, ex);
		wr(pwb_pkg::IDX_CHAN_A_EXTRA, 8'h00);
		wr(pwb_pkg::IDX_CHAN_B_WIDTH, 8'h02);
		wr(pwb_pkg::IDX_CHAN_A_WIDTH, 8'h02);
		wr(pwb_pkg::IDX_CLOCK_SELECT, cs);
		wr(pwb_pkg::IDX_PORT_CONFIG, pc);
		wr(pwb_pkg::IDX_CONTROL, ctl);
	endtask
	// Settle one window, then count high cycles of every pin output over one window
	task automatic measure(input int win);
		int i;
		repeat (win) @(posedge clk);
		cnt = '{0, 0, 0, 0, 0, 0};
		repeat (win)
		begin
			@(posedge clk);
			for (i = 0; i < 6; i++)
				cnt[i] += (pin[i] === 1'b1);
		end
	endtask
	task automatic wait_irq();
		int n;
		repeat (3) @(posedge clk);
		for (n = 0; n < 2000 && irq !== 1'b1; n++)
			@(posedge clk);
		if (irq !== 1'b1)
		begin
			fails++;
			conclude();
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		check("pins_idle", pin, 6'h00);
		rdchk("b_extra_reset", pwb_pkg::IDX_CHAN_B_EXTRA, 8'h00);
		rdchk("b_width_reset", pwb_pkg::IDX_CHAN_B_WIDTH, 8'h00);
		rdchk("prescale_reset", pwb_pkg::IDX_PRESCALE, 8'h00);
		rdchk("clk_sel_reset", pwb_pkg::IDX_CLOCK_SELECT, 8'h00);
		wr(pwb_pkg::IDX_CHAN_B_EXTRA, 8'hFF);
		rdchk("b_extra_low_zero", pwb_pkg::IDX_CHAN_B_EXTRA, 8'hF0);
		wr(pwb_pkg::IDX_CHAN_B_WIDTH, 8'hA5);
		rdchk("b_width_rw", pwb_pkg::IDX_CHAN_B_WIDTH, 8'hA5);
		wr(pwb_pkg::IDX_PRESCALE, 8'h5A);
		rdchk("prescale_rw", pwb_pkg::IDX_PRESCALE, 8'h5A);
		wr(pwb_pkg::IDX_CLOCK_SELECT, 8'hFE);
		rdchk("clk_sel_rw", pwb_pkg::IDX_CLOCK_SELECT, 8'hFE);
		apb(1'b0, 16'h7FB0, 8'h00);
		check("unmapped_err", er, 1'b1);
		check("unmapped_data", rd, 8'h00);
		// Misaligned write must be refused and leave the register alone
		addr_lsb = 2'h2;
		apb(1'b1, pwb_pkg::IDX_PRESCALE, 8'h33);
		addr_lsb = 2'h0;
		check("unaligned_err", er, 1'b1);
		rdchk("unaligned_no_write", pwb_pkg::IDX_PRESCALE, 8'h5A);
	endtask
	// Four pin styles on both pins, width two, sixteen-step fundamental
	task automatic t_styles();
		logic [3:0] st [4] = '{4'h5, 4'h9, 4'h7, 4'hB};
		int eo [4] = '{224, 32, 32, 0};
		int ee [4] = '{256, 256, 256, 224};
		int es [4] = '{0, 0, 256, 0};
		for (int i = 0; i < 4; i++)
		begin
			cfg(8'h00, 8'h00, 8'h00, {st[i], st[i]}, 8'h0C);
			measure(256);
			check("six_out", cnt[3], eo[i]);
			check("six_oe", cnt[4], ee[i]);
			check("six_slow", cnt[5], es[i]);
			check("seven_out", cnt[0], eo[i]);
			check("seven_oe", cnt[1], ee[i]);
			check("seven_slow", cnt[2], es[i]);
		end
	endtask
	// Extra pulses, prescaler, unused select bits, oscillator clock; channel A stopped
	task automatic t_wave();
		logic [7:0] dv [4] = '{8'h00, 8'h00, 8'h01, 8'h00};
		logic [7:0] ex [4] = '{8'h3F, 8'hF0, 8'h00, 8'h00};
		logic [7:0] cs [4] = '{8'h00, 8'h00, 8'hFE, 8'h01};
		int win [4] = '{256, 256, 512, 1024};
		int hi [4] = '{35, 47, 64, 128};
		for (int i = 0; i < 4; i++)
		begin
			cfg(dv[i], ex[i], cs[i], 8'h99, 8'h08);
			measure(win[i]);
			check("b_high_count", cnt[0], hi[i]);
			check("a_stopped_low", cnt[3], 0);
		end
		// Width change while running is picked up through the match buffer
		wr(pwb_pkg::IDX_CHAN_B_WIDTH, 8'h04);
		measure(1024);
		check("b_width_reload", cnt[0], 256);
	endtask
	// Overall period by interrupt spacing, then masking and clearing
	task automatic t_irq();
		int t1;
		cfg(8'h00, 8'h00, 8'h00, 8'h99, 8'h1B);
		wait_irq();
		t1 = cyc;
		wr(pwb_pkg::IDX_CONTROL, 8'h1B);
		wait_irq();
		check("overall_period", cyc - t1, 512);
		wr(pwb_pkg::IDX_IRQ_MASK, 8'h00);
		wr(pwb_pkg::IDX_IRQ_STATUS, 8'h01);
		repeat (600) @(posedge clk);
		check("irq_masked", irq, 1'b0);
		rdchk("flag_sticky", pwb_pkg::IDX_IRQ_STATUS, 8'h01);
		wr(pwb_pkg::IDX_IRQ_MASK, 8'h01);
		repeat (3) @(posedge clk);
		check("irq_unmasked", irq, 1'b1);
		wr(pwb_pkg::IDX_IRQ_STATUS, 8'h01);
		repeat (3) @(posedge clk);
		check("irq_cleared", irq, 1'b0);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_styles();
		t_wave();
		t_irq();
		conclude();
	end
endmodule
